//--- rtl/lar_pkg.sv
// Shared constants and types for the linear array readout link:
// a sensor end (two 64-pixel shift sections) and a controller end.
// Assumes both ends run on one 100 MHz system clock; the sensor clock
// is a divided strobe made by the controller and resynchronised.
//
// Contract
// - one sampled high start begins readout
// - controller drops start before next edge
// - start bit advances one stage per edge
// - falling stage bit resets that pixel integrator
// - edge 129 empties register, output floats
// - controller must supply the 129th edge
// - next start no earlier than edge 130
// - analog output floats outside pixel output
// - integration time equals start pulse spacing
// - two 64-pixel sections, own start, output
// - first chain output feeds second start
// - second chain output marks end of data
// - sensor clock drives transfer, selection, reset
package lar_pkg;

  // Array organisation
  localparam int SECTION_PIXELS = 64;
  localparam int SECTION_COUNT  = 2;
  localparam int ARRAY_PIXELS   = 128;
  localparam int SEC_IDX_W      = 6;
  localparam int PIX_IDX_W      = 7;
  localparam int LEVEL_W        = 8;
  localparam int EDGE_W         = 8;

  // Sequence edges, counted from the capture edge as edge 1
  localparam int SHIFT_OUT_EDGE  = 129;
  localparam int NEXT_START_EDGE = 130;
  localparam logic [EDGE_W-1:0] LAST_PIXEL_EDGE = EDGE_W'(SHIFT_OUT_EDGE - 1);
  localparam logic [EDGE_W-1:0] FIRST_EDGE      = 8'h01;

  // Sensor clock timing: least half period, rounded up to cycles
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCLK_HALF_NS  = 80;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DIV_W         = 4;
  localparam logic [DIV_W-1:0] DIV_FALL = DIV_W'(SCLK_HALF_CYC - 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(2 * SCLK_HALF_CYC - 1);

  // Reset values
  localparam logic              PIN_RESET   = 1'b0;
  localparam logic [LEVEL_W-1:0] LEVEL_RESET = 8'h00;

  // Controller states
  typedef enum logic [2:0] {
    CTL_IDLE = 3'b001,
    CTL_ARM  = 3'b010,
    CTL_RUN  = 3'b100
  } lar_ctl_state_type;

endpackage

//--- rtl/lar_link_if.sv
// Board-level link between controller and sensor array.
// Assumes the first chain output is wired to the second start input,
// and both analog outputs share one resolved line to the controller.
`timescale 1ns/1ps
interface lar_link_if;
  import lar_pkg::*;

  logic                 sensor_clk;
  logic                 first_section_start_in;
  logic                 second_section_start_in;
  logic                 first_section_chain_out;
  logic                 second_section_chain_out;
  logic [LEVEL_W-1:0]   first_section_analog_out;
  logic                 first_section_analog_oe;
  logic [LEVEL_W-1:0]   second_section_analog_out;
  logic                 second_section_analog_oe;
  logic [LEVEL_W-1:0]   analog_pixel_out;
  logic                 analog_pixel_drive;

  // Cascade wiring and the shared analog line
  assign second_section_start_in = first_section_chain_out;
  assign analog_pixel_drive      = first_section_analog_oe | second_section_analog_oe;
  assign analog_pixel_out = first_section_analog_oe  ? first_section_analog_out :
                            second_section_analog_oe ? second_section_analog_out :
                                                       LEVEL_RESET;

  modport sensor (
    input  sensor_clk,
    input  first_section_start_in,
    input  second_section_start_in,
    output first_section_chain_out,
    output second_section_chain_out,
    output first_section_analog_out,
    output first_section_analog_oe,
    output second_section_analog_out,
    output second_section_analog_oe
  );

  modport ctl (
    output sensor_clk,
    output first_section_start_in,
    input  second_section_chain_out,
    input  analog_pixel_out,
    input  analog_pixel_drive
  );

endinterface

//--- rtl/lar_ctl_end.sv
// Readout controller: divides the system clock into the sensor clock,
// issues start pulses and collects one sample per pixel.
// Assumes the sensor end sits on the other side of lar_link_if.
`timescale 1ns/1ps
module lar_ctl_end (
  input  wire logic                          i_clk,
  input  wire logic                          i_rst,
  lar_link_if.ctl                            link,
  input  wire logic                          i_frame_req,
  input  wire logic                          i_pix_ready,
  output logic                               o_pix_valid,
  output logic [lar_pkg::PIX_IDX_W-1:0]      o_pix_index,
  output logic [lar_pkg::LEVEL_W-1:0]        o_pix_level,
  output logic                               o_frame_busy,
  output logic                               o_frame_done,
  output logic                               o_end_of_data
);
  import lar_pkg::*;

  localparam int ENTRY_W = PIX_IDX_W + LEVEL_W;

  lar_ctl_state_type       state_reg;
  lar_ctl_state_type       state_next;
  logic [DIV_W-1:0]        div_reg;
  logic [DIV_W-1:0]        div_next;
  logic [EDGE_W-1:0]       edge_reg;
  logic [EDGE_W-1:0]       edge_next;
  logic                    sclk_reg;
  logic                    start_reg;
  logic                    start_next;
  logic                    done_reg;
  logic                    frame_busy_reg;
  logic [LEVEL_W-1:0]      ana_meta_reg;
  logic [LEVEL_W-1:0]      ana_sync_reg;
  logic                    drv_meta_reg;
  logic                    drv_sync_reg;
  logic                    eod_meta_reg;
  logic                    eod_sync_reg;
  logic [ENTRY_W-1:0]      out_reg;
  logic                    out_valid_reg;
  logic [ENTRY_W-1:0]      skid_reg;
  logic                    skid_valid_reg;

  // Phase decode of the divider
  wire logic               at_fall   = (div_reg == DIV_FALL);
  wire logic               at_last   = (div_reg == DIV_LAST);
  wire logic               running   = (state_reg == CTL_RUN);
  wire logic               buf_ready = ~skid_valid_reg;
  wire logic               sample    = running & at_last;
  wire logic               hold      = sample & ~buf_ready;
  wire logic               push      = sample & buf_ready;
  wire logic               rise      = at_last & ~hold;
  wire logic               out_free  = ~out_valid_reg | i_pix_ready;
  wire logic [LEVEL_W-1:0] sample_lvl = drv_sync_reg ? ana_sync_reg : LEVEL_RESET;
  wire logic [ENTRY_W-1:0] entry = {PIX_IDX_W'(edge_reg - FIRST_EDGE), sample_lvl};

  // Stalling the divider keeps the clock low, so a full buffer loses nothing
  assign div_next = hold ? div_reg : (at_last ? '0 : div_reg + 4'h1);

  // Start goes high in the low phase before capture, low right after it
  assign start_next = (state_reg == CTL_ARM && at_fall) ? 1'b1 :
                      (running && at_fall)              ? 1'b0 :
                                                          start_reg;

  // Sequencer: a new frame may only be armed after the 129th edge
  always_comb begin
    state_next = state_reg;
    edge_next  = edge_reg;
    unique case (state_reg)
      CTL_IDLE: begin
        if (i_frame_req) begin
          state_next = CTL_ARM;
        end
      end
      CTL_ARM: begin
        if (rise && start_reg) begin
          state_next = CTL_RUN;
          edge_next  = FIRST_EDGE;
        end
      end
      CTL_RUN: begin
        if (rise && edge_reg == LAST_PIXEL_EDGE) begin
          state_next = CTL_IDLE;
          edge_next  = '0;
        end else if (rise) begin
          edge_next  = edge_reg + 8'h01;
        end
      end
      default: begin
        state_next = CTL_IDLE;
        edge_next  = '0;
      end
    endcase
  end

  // Sequencer and sensor clock registers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= CTL_IDLE;
      div_reg   <= DIV_LAST;  // First high phase after reset is full width
      edge_reg  <= '0;
      sclk_reg  <= PIN_RESET;
      start_reg <= PIN_RESET;
      done_reg  <= 1'b0;
      frame_busy_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      div_reg   <= div_next;
      edge_reg  <= edge_next;
      sclk_reg  <= (div_next <= DIV_FALL);
      start_reg <= start_next;
      done_reg  <= running & (state_next == CTL_IDLE);
      frame_busy_reg <= (state_next != CTL_IDLE);
    end
  end

  // Pins from the sensor pass two flops before use
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ana_meta_reg <= LEVEL_RESET;
      ana_sync_reg <= LEVEL_RESET;
      drv_meta_reg <= 1'b0;
      drv_sync_reg <= 1'b0;
      eod_meta_reg <= 1'b0;
      eod_sync_reg <= 1'b0;
    end else begin
      ana_meta_reg <= link.analog_pixel_out;
      ana_sync_reg <= ana_meta_reg;
      drv_meta_reg <= link.analog_pixel_drive;
      drv_sync_reg <= drv_meta_reg;
      eod_meta_reg <= link.second_section_chain_out;
      eod_sync_reg <= eod_meta_reg;
    end
  end

  // Two-entry buffer: output stage plus one spare slot
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      out_reg        <= '0;
      out_valid_reg  <= 1'b0;
      skid_reg       <= '0;
      skid_valid_reg <= 1'b0;
    end else if (out_free && skid_valid_reg) begin
      out_reg        <= skid_reg;
      out_valid_reg  <= 1'b1;
      skid_reg       <= entry;
      skid_valid_reg <= push;
    end else if (out_free) begin
      out_reg        <= entry;
      out_valid_reg  <= push;
    end else if (push) begin
      skid_reg       <= entry;
      skid_valid_reg <= 1'b1;
    end
  end

  assign link.sensor_clk             = sclk_reg;
  assign link.first_section_start_in = start_reg;
  assign o_pix_valid   = out_valid_reg;
  assign o_pix_index   = out_reg[ENTRY_W-1:LEVEL_W];
  assign o_pix_level   = out_reg[LEVEL_W-1:0];
  assign o_frame_busy  = frame_busy_reg;
  assign o_frame_done  = done_reg;
  assign o_end_of_data = eod_sync_reg;

endmodule

//--- rtl/lar_sensor_end.sv
// Sensor end: two 64-stage shift sections that walk a start bit across
// the pixels, select each pixel onto its analog output, reset each
// integrator as its bit leaves, and pass the bit on at the chain output.
// Assumes the sensor clock and start pins arrive from another party and
// are therefore resynchronised to i_clk before any logic reads them.
// The user side supplies the level of the pixel named by each index.
`timescale 1ns/1ps
module lar_sensor_end (
  input  wire logic                             i_clk,
  input  wire logic                             i_rst,
  lar_link_if.sensor                            link,
  input  wire logic [lar_pkg::LEVEL_W-1:0]      i_first_level,
  input  wire logic [lar_pkg::LEVEL_W-1:0]      i_second_level,
  output logic [lar_pkg::SEC_IDX_W-1:0]         o_first_index,
  output logic                                  o_first_active,
  output logic [lar_pkg::SEC_IDX_W-1:0]         o_second_index,
  output logic                                  o_second_active,
  output logic [lar_pkg::ARRAY_PIXELS-1:0]      o_integ_reset,
  output logic                                  o_busy
);
  import lar_pkg::*;

  // Position of the single set bit in a section
  function automatic logic [SEC_IDX_W-1:0] onehot_index(
    input logic [SECTION_PIXELS-1:0] v
  );
    logic [SEC_IDX_W-1:0] r;
    r = '0;
    for (int b = 0; b < SECTION_PIXELS; b++) begin
      if (v[b]) begin
        r = r | b[SEC_IDX_W-1:0];
      end
    end
    return r;
  endfunction

  // Sensor clock synchroniser and rising edge detector
  logic                        sclk_meta_reg;
  logic                        sclk_sync_reg;
  logic                        sclk_prev_reg;

  // Per-section views gathered from the generate loop
  wire logic [SECTION_COUNT-1:0]  start_pin;
  wire logic [LEVEL_W-1:0]        level_in  [SECTION_COUNT];
  wire logic [LEVEL_W-1:0]        level_out [SECTION_COUNT];
  wire logic [SECTION_COUNT-1:0]  drive_out;
  wire logic [SECTION_COUNT-1:0]  chain_out;
  wire logic [SECTION_COUNT-1:0]  active_out;
  wire logic [SEC_IDX_W-1:0]      index_out [SECTION_COUNT];
  wire logic [SECTION_PIXELS-1:0] reset_out [SECTION_COUNT];

  // One shared clock event steers every section
  wire logic sclk_rise = sclk_sync_reg & ~sclk_prev_reg;

  // The clock pin is only read after two flops
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sclk_meta_reg <= PIN_RESET;
      sclk_sync_reg <= PIN_RESET;
      sclk_prev_reg <= PIN_RESET;
    end else begin
      sclk_meta_reg <= link.sensor_clk;
      sclk_sync_reg <= sclk_meta_reg;
      sclk_prev_reg <= sclk_sync_reg;
    end
  end

  // Each section has its own start pin and level source
  assign start_pin[0] = link.first_section_start_in;
  assign start_pin[1] = link.second_section_start_in;
  assign level_in[0]  = i_first_level;
  assign level_in[1]  = i_second_level;

  generate
    for (genvar s = 0; s < SECTION_COUNT; s++) begin : gen_sec
      logic                      start_meta_reg;
      logic                      start_sync_reg;
      logic [SECTION_PIXELS-1:0] shift_reg;
      logic [SECTION_PIXELS-1:0] shift_next;
      logic [SECTION_PIXELS-1:0] rst_reg;
      logic [SEC_IDX_W-1:0]      idx_reg;
      logic                      act_reg;
      logic                      oe_reg;
      logic [LEVEL_W-1:0]        lvl_reg;

      // Start and clock take the same two-flop path, so their
      // alignment at the pin is kept at the edge detector
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          start_meta_reg <= PIN_RESET;
          start_sync_reg <= PIN_RESET;
        end else begin
          start_meta_reg <= start_pin[s];
          start_sync_reg <= start_meta_reg;
        end
      end

      // A start sampled high on an edge enters stage 0; every edge moves
      // the bit one stage on and edge 129 pushes it out of section two
      assign shift_next = sclk_rise ?
                          {shift_reg[SECTION_PIXELS-2:0], start_sync_reg} :
                          shift_reg;

      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          shift_reg <= '0;
        end else begin
          shift_reg <= shift_next;
        end
      end

      // A stage falling from one to zero restarts that integrator,
      // so exposure runs from one readout to the next
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          rst_reg <= '0;
        end else begin
          rst_reg <= shift_reg & ~shift_next;
        end
      end

      // Selection pipeline: index first, then the level the user returns
      // for it; the output enable waits one cycle to match the level
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          idx_reg <= '0;
          act_reg <= 1'b0;
          oe_reg  <= 1'b0;
          lvl_reg <= LEVEL_RESET;
        end else begin
          idx_reg <= onehot_index(shift_reg);
          act_reg <= |shift_reg;
          oe_reg  <= act_reg;
          lvl_reg <= act_reg ? level_in[s] : LEVEL_RESET;
        end
      end

      assign level_out[s]  = lvl_reg;
      assign drive_out[s]  = oe_reg;
      assign chain_out[s]  = shift_reg[SECTION_PIXELS-1];
      assign active_out[s] = act_reg;
      assign index_out[s]  = idx_reg;
      assign reset_out[s]  = rst_reg;
    end
  endgenerate

  // Busy while any stage of either section holds the bit
  logic busy_reg;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= |active_out;
    end
  end

  // Analog outputs float whenever their section is not selecting a pixel
  assign link.first_section_analog_out  = level_out[0];
  assign link.first_section_analog_oe   = drive_out[0];
  assign link.second_section_analog_out = level_out[1];
  assign link.second_section_analog_oe  = drive_out[1];

  // Last stage of each section leaves as its chain output; the first
  // feeds section two, the second marks end of data or cascades on
  assign link.first_section_chain_out  = chain_out[0];
  assign link.second_section_chain_out = chain_out[1];

  // User-side views, all taken straight from flops
  assign o_first_index   = index_out[0];
  assign o_first_active  = active_out[0];
  assign o_second_index  = index_out[1];
  assign o_second_active = active_out[1];
  assign o_integ_reset   = {reset_out[1], reset_out[0]};
  assign o_busy          = busy_reg;

endmodule

//--- verification/lar_link_asserts.sv
// Concurrent checks on the signals of the link between both ends.
// Assumes one i_clk domain; the sensor clock is a strobe made from it.
`timescale 1ns/1ps
module lar_link_asserts (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic sensor_clk,
  input  wire logic first_section_start_in,
  input  wire logic first_section_chain_out,
  input  wire logic second_section_chain_out,
  input  wire logic first_section_analog_oe,
  input  wire logic second_section_analog_oe,
  input  wire logic analog_pixel_drive
);
  import lar_pkg::*;
  logic       sclk_d_reg;
  logic [7:0] edge_cnt_reg;
  logic [7:0] edge_cnt_next;
  logic       sclk_rise;
  logic       start_taken;

  // Edge count since capture, held at ff; ff means no frame seen or 254 edges past capture, so idle never matches
  assign sclk_rise     = sensor_clk & ~sclk_d_reg;
  assign start_taken   = sclk_rise & first_section_start_in;
  assign edge_cnt_next = start_taken ? 8'h01 :
                         (sclk_rise && edge_cnt_reg != 8'hff) ? edge_cnt_reg + 8'h01 :
                         edge_cnt_reg;

  // Kept short: the count only moves on a sensor clock rise
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sclk_d_reg   <= 1'b0;
      edge_cnt_reg <= 8'hff;
    end else begin
      sclk_d_reg   <= sensor_clk;
      edge_cnt_reg <= edge_cnt_next;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_sclk_high;
    sensor_clk[*8] ##1 !sensor_clk;
  endsequence
  sequence s_last_edge;
    $rose(sensor_clk) && edge_cnt_reg == 8'h80;
  endsequence

  // A second rise with start high would load a second bit
  a_start_one_edge: assert property ($rose(sensor_clk) && first_section_start_in |-> edge_cnt_reg >= 8'h81)
    else $error("start seen high on two sensor clock rises");
  a_start_spacing: assert property ($rose(first_section_start_in) |-> edge_cnt_reg >= 8'h81)
    else $error("start raised before edge 129 of the frame");
  a_sclk_high_phase: assert property ($rose(sensor_clk) |-> s_sclk_high)
    else $error("sensor clock high phase not 8 cycles");
  a_drive_in_frame: assert property (analog_pixel_drive |-> edge_cnt_reg >= 8'h01 && edge_cnt_reg <= 8'h81)
    else $error("analog line driven outside the output phase");
  a_float_after_out: assert property (s_last_edge |-> ##[1:8] !analog_pixel_drive)
    else $error("analog line still driven after edge 129");
  a_first_oe_start: assert property ($rose(first_section_analog_oe) |-> edge_cnt_reg == 8'h01)
    else $error("first section output did not begin at edge 1");
  a_second_oe_start: assert property ($rose(second_section_analog_oe) |-> edge_cnt_reg == 8'h41)
    else $error("second section output did not begin at edge 65");
  a_chain_first_pix: assert property ($rose(first_section_chain_out) |-> edge_cnt_reg == 8'h40)
    else $error("first chain output not with pixel 64");
  a_chain_end_data: assert property ($rose(second_section_chain_out) |-> edge_cnt_reg == 8'h80)
    else $error("second chain output not with pixel 128");
  a_hand_over: assert property ($fell(first_section_chain_out) |-> ##[1:4] $rose(second_section_analog_oe))
    else $error("second section did not take over the bit");
  a_single_driver: assert property (!(first_section_analog_oe && second_section_analog_oe))
    else $error("both sections drive the analog line");
endmodule

//--- verification/tb_top.sv
// Self-checking bench: controller and sensor ends joined by the link.
// Assumes a 100 MHz i_clk; pixel levels follow the shown index and a salt.
`timescale 1ns/1ps
module tb_top;
  import lar_pkg::*;
  logic                 i_clk = 1'b0;
  logic                 i_rst = 1'b1;
  logic                 i_frame_req = 1'b0;
  logic                 i_pix_ready = 1'b0;
  logic                 stall_en = 1'b0;
  logic [LEVEL_W-1:0]   i_first_level = LEVEL_RESET;
  logic [LEVEL_W-1:0]   i_second_level = LEVEL_RESET;
  logic [7:0]           salt = 8'h00;
  logic [31:0]          rnd = 32'hb93f;
  logic                 o_pix_valid;
  logic [PIX_IDX_W-1:0] o_pix_index;
  logic [LEVEL_W-1:0]   o_pix_level;
  logic                 o_frame_busy;
  logic                 o_frame_done;
  logic                 o_end_of_data;
  logic [SEC_IDX_W-1:0] o_first_index;
  logic [SEC_IDX_W-1:0] o_second_index;
  logic                 o_first_active;
  logic                 o_second_active;
  logic [1:0]           act_d = 2'b00;
  int                   act_cnt = 0;
  int                   ovl_cnt = 0;
  logic [127:0]         o_integ_reset;
  logic                 o_busy;
  logic                 eod_d = 1'b0;
  logic [127:0]         seen = '0;
  int                   errors = 0;
  int                   num_checks = 0;
  int                   done_cnt = 0;
  int                   eod_cnt = 0;
  int                   rst_cnt = 0;

  lar_link_if lar_link_if_inst ();
  lar_ctl_end lar_ctl_end_inst (.i_clk(i_clk), .i_rst(i_rst), .link(lar_link_if_inst.ctl),
    .i_frame_req(i_frame_req), .i_pix_ready(i_pix_ready), .o_pix_valid(o_pix_valid),
    .o_pix_index(o_pix_index), .o_pix_level(o_pix_level), .o_frame_busy(o_frame_busy),
    .o_frame_done(o_frame_done), .o_end_of_data(o_end_of_data));
  lar_sensor_end lar_sensor_end_inst (.i_clk(i_clk), .i_rst(i_rst),
    .link(lar_link_if_inst.sensor), .i_first_level(i_first_level),
    .i_second_level(i_second_level), .o_first_index(o_first_index),
    .o_first_active(o_first_active), .o_second_index(o_second_index),
    .o_second_active(o_second_active), .o_integ_reset(o_integ_reset),
    .o_busy(o_busy));
  lar_link_asserts lar_link_asserts_inst (.i_clk(i_clk), .i_rst(i_rst),
    .sensor_clk(lar_link_if_inst.sensor_clk),
    .first_section_start_in(lar_link_if_inst.first_section_start_in),
    .first_section_chain_out(lar_link_if_inst.first_section_chain_out),
    .second_section_chain_out(lar_link_if_inst.second_section_chain_out),
    .first_section_analog_oe(lar_link_if_inst.first_section_analog_oe),
    .second_section_analog_oe(lar_link_if_inst.second_section_analog_oe),
    .analog_pixel_drive(lar_link_if_inst.analog_pixel_drive));

  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  // Distinct level per pixel, so a slip of one position shows up
  function automatic logic [7:0] lvl(logic [7:0] s, logic [6:0] p);
    return s ^ {p, 1'b1};
  endfunction

  task automatic check_pix(logic [6:0] gi, logic [7:0] gl, logic [6:0] ei, logic [7:0] el);
    num_checks++;
    if (gi !== ei || gl !== el) begin
      errors++;
      $display("Error t=%0t pixel got %h/%h exp %h/%h", $time, gi, gl, ei, el);
    end
  endtask

  task automatic check_word(logic [127:0] got, logic [127:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Take 128 pixels in order; handshake judged at the settled negedge
  task automatic get_frame(input logic drop_req);
    int  n;
    int  w;
    logic got;
    for (n = 0; n < 128; n++) begin
      got = 1'b0;
      for (w = 0; w < 800 && !got; w++) begin
        @(negedge i_clk);
        got = (o_pix_valid === 1'b1 && i_pix_ready === 1'b1);
      end
      if (!got) begin
        errors++;
        summarize();
      end
      check_pix(o_pix_index, o_pix_level, 7'(n), lvl(salt, 7'(n)));
      @(posedge i_clk);
      if (drop_req) i_frame_req <= 1'b0;
    end
  endtask

  // Both ends idle; sensor end lags the controller by a few cycles
  task automatic wait_idle;
    int w;
    for (w = 0; w < 400; w++) begin
      @(negedge i_clk);
      if (o_frame_busy === 1'b0 && o_busy === 1'b0) break;
    end
    if (w == 400) begin
      errors++;
      summarize();
    end
    repeat (8) @(negedge i_clk);
  endtask

  always #5 i_clk = ~i_clk;

  // Random consumer stalls, user levels and event tallies
  always @(posedge i_clk) begin
    rnd            <= xs(rnd);
    i_pix_ready    <= !stall_en || rnd[3:2] != 2'b00;
    i_first_level  <= lvl(salt, {1'b0, o_first_index});
    i_second_level <= lvl(salt, {1'b1, o_second_index});
    if (!i_rst) begin
      done_cnt += (o_frame_done === 1'b1);
      eod_cnt  += (o_end_of_data === 1'b1 && eod_d !== 1'b1);
      rst_cnt  += $countones(o_integ_reset);
      seen     |= o_integ_reset;
      eod_d    <= o_end_of_data;
      act_cnt  += (o_first_active === 1'b1 && act_d[0] !== 1'b1);
      act_cnt  += (o_second_active === 1'b1 && act_d[1] !== 1'b1);
      ovl_cnt  += (o_first_active === 1'b1 && o_second_active === 1'b1);
      act_d    <= {o_second_active, o_first_active};
    end
  end

  initial begin
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    // Plain frame, consumer always ready
    @(negedge i_clk);
    salt = rnd[7:0];
    @(posedge i_clk);
    i_frame_req <= 1'b1;
    get_frame(1'b1);
    wait_idle();
    // Stalling consumer; request held so the next frame follows at edge 130
    @(negedge i_clk);
    salt     = rnd[15:8];
    stall_en = 1'b1;
    @(posedge i_clk);
    i_frame_req <= 1'b1;
    get_frame(1'b0);
    get_frame(1'b1);
    wait_idle();
    check_word(done_cnt, 3);
    check_word(eod_cnt, 3);
    check_word(rst_cnt, 384);
    check_word(act_cnt, 6);
    check_word(ovl_cnt, 0);
    check_word(seen, {128{1'b1}});
    check_word(lar_link_if_inst.analog_pixel_drive, 0);
    check_word(lar_link_if_inst.analog_pixel_out, 0);
    summarize();
  end
endmodule
